// File: rtl/dmc_ctrl.sv
// Descriptor FIFO and DMA enable, reset and descriptor control top
`timescale 1ns/1ps
module dmc_fifo #(
    parameter int W = 32,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt_reg != (AW+1)'(D);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rptr_reg];
    assign level = cnt_reg;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_reg] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else if (flush) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wptr_reg <= push ? wptr_reg + 1'b1 : wptr_reg;
            rptr_reg <= pop ? rptr_reg + 1'b1 : rptr_reg;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// Summary of operation
// RULE1 - Global DMA enable bit starts the controller; clearing it stops new work.
// RULE2 - Select channel first; then channel enable bit one enables, zero disables it.
// RULE3 - Checksum enable bit switches checksum unit on with one, off with zero.
// RULE4 - Soft reset acts only with both disabled; clears all but debug control.
// RULE5 - Channel reset restores selected channel state, only while that channel is disabled.
// RULE6 - Software prepares a valid first descriptor before enabling and triggering a channel.
// RULE7 - First descriptor defines first block; fetched words feed the transfer engine.
// RULE8 - Software keeps descriptors in SRAM; fetches go only to the SRAM port.
// RULE9 - Descriptors come from descriptor base; write-back goes to write-back base.
// RULE10 - Software configures checksum source and polynomial before enabling checksum.
// RULE11 - Channel enable and reset writes touch only the selected channel.
module dmc_ctrl #(
    parameter int NCH = 4,
    parameter int CHW = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Channel triggers, same clock
    input wire logic [NCH-1:0] chan_trigger,
    // SRAM descriptor read port
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    // Descriptor stream to transfer engine
    output logic desc_valid,
    input wire logic desc_ready,
    output logic [dmc_pkg::FIFO_WIDTH-1:0] desc_data,
    // Control state
    output logic dma_active,
    output logic checksum_on,
    output logic [dmc_pkg::CKCFG_W-1:0] checksum_cfg,
    output logic debug_run,
    output logic [NCH-1:0] chan_enabled,
    output logic [31:0] writeback_addr
);
    import dmc_pkg::*;

    function automatic logic [NCH-1:0] chan_mask(input logic [CHW-1:0] ch);
        chan_mask = {{(NCH-1){1'b0}}, 1'b1} << ch;
    endfunction

    function automatic logic [CHW-1:0] first_one(input logic [NCH-1:0] v);
        first_one = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_one = CHW'(i);
            end
        end
    endfunction

    function automatic logic [31:0] desc_addr(input logic [31:0] base,
            input logic [CHW-1:0] ch, input logic [IDXW-1:0] idx);
        desc_addr = base + {{(30-CHW-IDXW){1'b0}}, ch, idx, 2'b00};
    endfunction

    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_mux;
    logic hreadyout_reg;
    logic dma_en_reg;
    logic ck_en_reg;
    logic [CKCFG_W-1:0] ckcfg_reg;
    logic dbg_reg;
    logic [31:0] dbase_reg;
    logic [31:0] wbase_reg;
    logic [CHW-1:0] chsel_reg;
    logic [NCH-1:0] chen_reg;
    logic [NCH-1:0] pend_reg;
    logic bad_reg;
    dmc_fetch_e st_reg;
    dmc_fetch_e st_next;
    logic [CHW-1:0] ch_reg;
    logic [IDXW-1:0] idx_reg;
    logic mem_req_reg;
    logic [31:0] mem_addr_reg;
    logic [31:0] wb_addr_reg;
    logic dv_reg;
    logic [FIFO_WIDTH-1:0] dd_reg;
    logic f_in_ready;
    logic f_out_valid;
    logic [FIFO_WIDTH-1:0] f_out_data;
    logic [$clog2(FIFO_DEPTH):0] f_level;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Bus decode
    wire acc = hsel && hready && htrans[1];
    wire w_ctrl = wr_pend_reg && addr_reg == OFS_CTRL;
    wire w_ch = wr_pend_reg && addr_reg == OFS_CHCTL;
    wire sreset_ok = !dma_en_reg && !ck_en_reg;
    wire do_sreset = w_ctrl && hwdata[CTRL_SOFT_RESET_BIT] && sreset_ok;
    wire w_ctrl_norm = w_ctrl && !hwdata[CTRL_SOFT_RESET_BIT];
    wire w_en = w_ch && !hwdata[CH_SOFT_RESET_BIT];
    wire ch_rst = w_ch && hwdata[CH_SOFT_RESET_BIT];
    wire [NCH-1:0] sel_mask = chan_mask(chsel_reg);
    wire [NCH-1:0] rst_mask = ch_rst ? (sel_mask & ~chen_reg) : '0;

    // Fetch arbitration
    wire [NCH-1:0] ready_ch = pend_reg & chen_reg;
    wire start = st_reg == DMC_IDLE && dma_en_reg && |ready_ch;
    wire [CHW-1:0] pick = first_one(ready_ch);
    wire [NCH-1:0] grant_mask = start ? chan_mask(pick) : '0;
    wire f_push = st_reg == DMC_WAIT && mem_rvalid;
    wire f_pop = !dv_reg || desc_ready;
    wire word0_bad = f_push && idx_reg == '0 && !mem_rdata[DESC_VALID_BIT];

    wire [NCH-1:0] chen_next = do_sreset ? '0 :
        !w_en ? chen_reg :
        hwdata[CH_EN_BIT] ? (chen_reg | sel_mask) : (chen_reg & ~sel_mask); // RULE2 RULE11
    wire [NCH-1:0] pend_next = do_sreset ? '0 :
        (pend_reg & ~grant_mask & ~rst_mask) | (chan_trigger & chen_reg); // RULE5 RULE11

    always_comb begin
        rd_mux = RST_WORD;
        case (addr_reg)
            OFS_CTRL: begin
                rd_mux[CTRL_DMAEN_BIT] = dma_en_reg;
                rd_mux[CTRL_CKEN_BIT] = ck_en_reg;
            end
            OFS_CKCFG: rd_mux[CKCFG_W-1:0] = ckcfg_reg;
            OFS_DBG: rd_mux[0] = dbg_reg;
            OFS_DBASE: rd_mux = dbase_reg;
            OFS_WBASE: rd_mux = wbase_reg;
            OFS_CHSEL: rd_mux[CHW-1:0] = chsel_reg;
            OFS_CHCTL: rd_mux[CH_EN_BIT] = |(chen_reg & sel_mask);
            OFS_STAT: begin
                rd_mux[STAT_BUSY_BIT] = st_reg != DMC_IDLE;
                rd_mux[STAT_BAD_BIT] = bad_reg;
                rd_mux[STAT_LVL_LSB +: $clog2(FIFO_DEPTH)+1] = f_level;
            end
            default: rd_mux = RST_WORD;
        endcase
    end

    // Reads take one wait state so a preceding write is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= '0;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= RST_WORD;
        end else begin
            wr_pend_reg <= acc && hwrite;
            rd_pend_reg <= acc && !hwrite;
            addr_reg <= acc ? haddr[7:0] : addr_reg;
            hreadyout_reg <= !(acc && !hwrite);
            hrdata_reg <= rd_pend_reg ? rd_mux : hrdata_reg;
        end
    end

    sequence s_read_slot;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_wait_state: assert property (acc && !hwrite |=> s_read_slot)
        else $error("read wait state wrong");

    // Debug control survives soft reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbg_reg <= RST_DBG;
        end else if (wr_pend_reg && addr_reg == OFS_DBG) begin
            dbg_reg <= hwdata[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_en_reg <= 1'b0;
            ck_en_reg <= 1'b0;
            ckcfg_reg <= RST_CKCFG;
            dbase_reg <= RST_WORD;
            wbase_reg <= RST_WORD;
            chsel_reg <= '0;
        end else if (do_sreset) begin // RULE4
            dma_en_reg <= 1'b0;
            ck_en_reg <= 1'b0;
            ckcfg_reg <= RST_CKCFG;
            dbase_reg <= RST_WORD;
            wbase_reg <= RST_WORD;
            chsel_reg <= '0;
        end else if (wr_pend_reg) begin
            if (w_ctrl_norm) begin
                dma_en_reg <= hwdata[CTRL_DMAEN_BIT]; // RULE1
                ck_en_reg <= hwdata[CTRL_CKEN_BIT]; // RULE3
            end
            if (addr_reg == OFS_CKCFG) begin
                ckcfg_reg <= hwdata[CKCFG_W-1:0];
            end
            if (addr_reg == OFS_DBASE) begin
                dbase_reg <= {hwdata[31:2], 2'b00};
            end
            if (addr_reg == OFS_WBASE) begin
                wbase_reg <= {hwdata[31:2], 2'b00};
            end
            if (addr_reg == OFS_CHSEL) begin
                chsel_reg <= hwdata[CHW-1:0];
            end
        end
    end

    a_dma_enable_follow: assert property ( // RULE1
        w_ctrl_norm |=> dma_active == $past(hwdata[CTRL_DMAEN_BIT]))
        else $error("global enable not taken");
    a_checksum_follow: assert property ( // RULE3
        w_ctrl_norm |=> checksum_on == $past(hwdata[CTRL_CKEN_BIT]))
        else $error("checksum enable not taken");
    a_soft_reset_clear: assert property ( // RULE4
        do_sreset |=> dbase_reg == RST_WORD && chen_reg == '0 && $stable(dbg_reg))
        else $error("soft reset incomplete");
    a_soft_reset_block: assert property ( // RULE4
        w_ctrl && hwdata[CTRL_SOFT_RESET_BIT] && !sreset_ok |=>
        $stable(dbase_reg) && $stable(chen_reg) && dma_active == $past(dma_en_reg))
        else $error("soft reset while enabled");

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chen_reg <= '0;
            pend_reg <= '0;
        end else begin
            chen_reg <= chen_next;
            pend_reg <= pend_next;
        end
    end

    a_chan_enable_sel: assert property ( // RULE2
        w_en |=> chan_enabled[$past(chsel_reg)] == $past(hwdata[CH_EN_BIT]))
        else $error("channel enable not taken");
    a_chan_reset_pend: assert property ( // RULE5
        ch_rst && !chen_reg[chsel_reg] |=> !pend_reg[$past(chsel_reg)])
        else $error("channel reset ignored");
    a_other_chan_kept: assert property ( // RULE11
        w_ch |=> ((chen_reg ^ $past(chen_reg)) & ~$past(sel_mask)) == '0)
        else $error("other channel changed");

    // Descriptor fetch, one word at a time, only with FIFO room
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            DMC_IDLE: st_next = start ? DMC_REQ : DMC_IDLE; // RULE1 RULE7
            DMC_REQ: st_next = f_in_ready ? DMC_WAIT : DMC_REQ;
            DMC_WAIT: begin
                if (mem_rvalid) begin
                    st_next = idx_reg == LAST_IDX ? DMC_IDLE : DMC_REQ;
                end
            end
            default: st_next = DMC_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= DMC_IDLE;
            ch_reg <= '0;
            idx_reg <= '0;
            wb_addr_reg <= RST_WORD;
        end else if (do_sreset) begin
            st_reg <= DMC_IDLE;
            idx_reg <= '0;
            wb_addr_reg <= RST_WORD;
        end else begin
            st_reg <= st_next;
            ch_reg <= start ? pick : ch_reg;
            idx_reg <= start ? '0 : f_push ? idx_reg + 1'b1 : idx_reg;
            wb_addr_reg <= start ? desc_addr(wbase_reg, pick, '0) : wb_addr_reg; // RULE9
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_req_reg <= 1'b0;
            mem_addr_reg <= RST_WORD;
        end else begin
            mem_req_reg <= st_reg == DMC_REQ && f_in_ready && !do_sreset; // RULE8
            if (st_reg == DMC_REQ && f_in_ready) begin
                mem_addr_reg <= desc_addr(dbase_reg, ch_reg, idx_reg); // RULE9
            end
        end
    end

    // First word without its valid mark is flagged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bad_reg <= 1'b0;
        end else if (word0_bad) begin // RULE6 RULE7
            bad_reg <= 1'b1;
        end else if (do_sreset) begin
            bad_reg <= 1'b0;
        end
    end

    sequence s_first_req;
        st_reg == DMC_REQ && idx_reg == '0 && f_in_ready && !do_sreset;
    endsequence
    a_fetch_from_base: assert property ( // RULE9
        s_first_req |=> mem_req && mem_addr == desc_addr($past(dbase_reg), ch_reg, '0))
        else $error("descriptor address not from base");
    a_writeback_base: assert property ( // RULE9
        start && !do_sreset |=> writeback_addr == desc_addr($past(wbase_reg), $past(pick), '0))
        else $error("write-back address not from base");
    a_idle_when_off: assert property ( // RULE1
        st_reg == DMC_IDLE && !dma_en_reg |=> st_reg == DMC_IDLE && !mem_req)
        else $error("fetch while disabled");
    a_invalid_flag: assert property ( // RULE7
        word0_bad |=> bad_reg ##1 (bad_reg || $past(do_sreset)))
        else $error("invalid descriptor not flagged");

    dmc_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
        .clk(hclk),
        .rst_n(hresetn),
        .flush(do_sreset),
        .in_valid(f_push),
        .in_ready(f_in_ready),
        .in_data(mem_rdata),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_out_data),
        .level(f_level)
    );

    // Output stage so the stream comes from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dv_reg <= 1'b0;
            dd_reg <= '0;
        end else if (do_sreset) begin
            dv_reg <= 1'b0;
        end else if (f_pop) begin
            dv_reg <= f_out_valid;
            dd_reg <= f_out_valid ? f_out_data : dd_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign mem_req = mem_req_reg;
    assign mem_addr = mem_addr_reg;
    assign desc_valid = dv_reg;
    assign desc_data = dd_reg;
    assign dma_active = dma_en_reg;
    assign checksum_on = ck_en_reg;
    assign checksum_cfg = ckcfg_reg;
    assign debug_run = dbg_reg;
    assign chan_enabled = chen_reg;
    assign writeback_addr = wb_addr_reg;
endmodule

// File: rtl/dmc_pkg.sv
// Constants for the DMA enable, reset and descriptor control slice
package dmc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CKCFG = 8'h04;
    localparam logic [7:0] OFS_DBG = 8'h08;
    localparam logic [7:0] OFS_DBASE = 8'h0C;
    localparam logic [7:0] OFS_WBASE = 8'h10;
    localparam logic [7:0] OFS_CHSEL = 8'h14;
    localparam logic [7:0] OFS_CHCTL = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    // Field positions
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int CTRL_DMAEN_BIT = 1;
    localparam int CTRL_CKEN_BIT = 2;
    localparam int CH_SOFT_RESET_BIT = 0;
    localparam int CH_EN_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_BAD_BIT = 1;
    localparam int STAT_LVL_LSB = 8;
    localparam int DESC_VALID_BIT = 0;
    localparam int CKCFG_W = 4;
    // Values after reset
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [3:0] RST_CKCFG = 4'h0;
    localparam logic RST_DBG = 1'b0;
    // Descriptor shape: four words, sixteen bytes
    localparam int IDXW = 2;
    localparam logic [1:0] LAST_IDX = 2'h3;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 32;
    typedef enum logic [1:0] {DMC_IDLE, DMC_REQ, DMC_WAIT} dmc_fetch_e;
endpackage

// File: tb/dmc_sram_model.sv
// Behavioural SRAM answering descriptor word requests
`timescale 1ns/1ps
module dmc_sram_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Scenario controls
    input wire logic slow,
    input wire logic bad,
    // Descriptor read port
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    logic busy;
    logic [1:0] cnt;
    logic [31:0] a;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 2'h0;
            a <= 32'h0000_0000;
            mem_rvalid <= 1'b0;
            mem_rdata <= 32'h0000_0000;
        end else begin
            mem_rvalid <= 1'b0;
            if (mem_req) begin
                busy <= 1'b1;
                a <= mem_addr;
                cnt <= slow ? 2'h3 : 2'h0;
                mem_rdata <= ~mem_rdata;
            end else if (busy && cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
                mem_rdata <= ~mem_rdata;
            end else if (busy) begin
                busy <= 1'b0;
                mem_rvalid <= 1'b1;
                // Word zero carries the valid mark unless told otherwise
                mem_rdata <= {a[30:0], !(bad && a[3:0] == 4'h0)};
            end else begin
                mem_rdata <= ~mem_rdata;
            end
        end
    end
endmodule

// File: tb/tb_dmc_ctrl.sv
// Self-checking bench for the DMA enable, reset and descriptor slice
`timescale 1ns/1ps
module tb_dmc_ctrl;
    import dmc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [3:0] chan_trigger = 4'h0;
    logic mem_req;
    logic mem_rvalid;
    logic [31:0] mem_addr;
    logic [31:0] mem_rdata;
    logic desc_valid;
    logic desc_ready = 1'b0;
    logic [31:0] desc_data;
    logic dma_active;
    logic checksum_on;
    logic debug_run;
    logic [3:0] checksum_cfg;
    logic [3:0] chan_enabled;
    logic [31:0] writeback_addr;
    logic slow = 1'b0;
    logic bad = 1'b0;
    int n_fail = 0;
    int tests_run = 0;
    int n_req = 0;
    logic [31:0] addr_q[$];
    logic [31:0] desc_q[$];
    logic [31:0] rd;
    always #5 hclk = ~hclk;
    dmc_ctrl #(.NCH(4), .CHW(2)) dmc_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .chan_trigger(chan_trigger), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .desc_valid(desc_valid),
        .desc_ready(desc_ready), .desc_data(desc_data), .dma_active(dma_active),
        .checksum_on(checksum_on), .checksum_cfg(checksum_cfg), .debug_run(debug_run),
        .chan_enabled(chan_enabled), .writeback_addr(writeback_addr));
    dmc_sram_model dmc_sram_model_i (.clk(hclk), .rst_n(hresetn), .slow(slow), .bad(bad),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    // Record SRAM requests and accepted descriptor words
    always @(posedge hclk) begin
        if (mem_req === 1'b1) begin
            n_req++;
            addr_q.push_back(mem_addr);
        end
        if (desc_valid === 1'b1 && desc_ready === 1'b1) begin
            desc_q.push_back(desc_data);
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task lost;
        n_fail++;
        end_of_test;
    endtask
    task wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 50) lost;
    endtask
    task write(input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
    endtask
    task read(input logic [7:0] a, output logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        wait_rdy;
        htrans <= 2'h0;
        wait_rdy;
        d = hrdata;
    endtask
    task pulse(input logic [3:0] m);
        @(posedge hclk);
        chan_trigger <= m;
        @(posedge hclk);
        chan_trigger <= 4'h0;
    endtask
    task wait_desc(input int n);
        int k;
        for (k = 0; k < 500 && desc_q.size() < n; k++) @(posedge hclk);
        if (desc_q.size() < n) lost;
    endtask
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[30:0], 1'b1};
    endfunction
    task t_reset;
        for (int a = 0; a <= 36; a += 4) begin
            read(8'(a), rd);
            check(rd, RST_WORD);
        end
        write(8'h24, 32'hFFFF_FFFF);
        read(8'h24, rd);
        check(rd, 32'h0000_0000);
    endtask
    task t_enables;
        write(OFS_CKCFG, 32'h0000_0005);
        write(OFS_CTRL, 32'h0000_0002);
        @(posedge hclk);
        check({31'h0, dma_active}, 32'h1);
        write(OFS_CTRL, 32'h0000_0006);
        @(posedge hclk);
        check({27'h0, checksum_cfg, checksum_on}, 32'h0000_000B);
        read(OFS_CTRL, rd);
        check(rd, 32'h0000_0006);
        write(OFS_CTRL, 32'h0000_0000);
        @(posedge hclk);
        check({30'h0, dma_active, checksum_on}, 32'h0);
    endtask
    task t_channels;
        for (int c = 0; c < 4; c++) begin
            write(OFS_CHSEL, 32'(c));
            write(OFS_CHCTL, 32'h0000_0002);
        end
        @(posedge hclk);
        check({28'h0, chan_enabled}, 32'hF);
        write(OFS_CHSEL, 32'h0000_0001);
        write(OFS_CHCTL, 32'h0000_0000);
        @(posedge hclk);
        check({28'h0, chan_enabled}, 32'hD);
        read(OFS_CHCTL, rd);
        check(rd, 32'h0000_0000);
        write(OFS_CHCTL, 32'h0000_0001);
        write(OFS_CHSEL, 32'h0000_0002);
        read(OFS_CHCTL, rd);
        check(rd, 32'h0000_0002);
        write(OFS_CHCTL, 32'h0000_0001);
        @(posedge hclk);
        check({28'h0, chan_enabled}, 32'hD);
    endtask
    task t_soft;
        write(OFS_DBG, 32'h0000_0001);
        write(OFS_DBASE, 32'h1234_5670);
        write(OFS_CTRL, 32'h0000_0002);
        write(OFS_CTRL, 32'h0000_0001);
        read(OFS_DBASE, rd);
        check(rd, 32'h1234_5670);
        check({31'h0, dma_active}, 32'h1);
        check({31'h0, hresp}, 32'h0);
        write(OFS_CTRL, 32'h0000_0000);
        write(OFS_CTRL, 32'h0000_0001);
        @(posedge hclk);
        check({23'h0, checksum_cfg, chan_enabled, debug_run}, 32'h1);
        read(OFS_DBG, rd);
        check(rd, 32'h0000_0001);
        read(OFS_DBASE, rd);
        check(rd, 32'h0000_0000);
    endtask
    task t_fetch;
        write(OFS_DBASE, 32'h2000_0100);
        write(OFS_WBASE, 32'h2000_0400);
        write(OFS_CHSEL, 32'h0000_0002);
        write(OFS_CHCTL, 32'h0000_0002);
        write(OFS_CTRL, 32'h0000_0002);
        slow <= 1'b1;
        addr_q.delete();
        desc_q.delete();
        @(posedge hclk);
        desc_ready <= 1'b1;
        pulse(4'h4);
        wait_desc(4);
        check(writeback_addr, 32'h2000_0420);
        for (int i = 0; i < 4; i++) begin
            check(addr_q[i], 32'h2000_0120 + 32'(4 * i));
            check(desc_q[i], pat(32'h2000_0120 + 32'(4 * i)));
        end
        read(OFS_STAT, rd);
        check(rd & 32'h0000_0002, 32'h0000_0000);
    endtask
    task t_fill;
        slow <= 1'b0;
        @(posedge hclk);
        desc_ready <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            write(OFS_CHSEL, 32'(c));
            write(OFS_CHCTL, 32'h0000_0002);
        end
        n_req = 0;
        desc_q.delete();
        pulse(4'hF);
        for (int k = 0; k < 500 && n_req < 16; k++) @(posedge hclk);
        pulse(4'h1);
        repeat (60) @(posedge hclk);
        check(32'(n_req), 32'(FIFO_DEPTH + 1));
        read(OFS_STAT, rd);
        check({27'h0, rd[12:8]}, 32'(FIFO_DEPTH));
        @(posedge hclk);
        desc_ready <= 1'b1;
        wait_desc(20);
        repeat (5) @(posedge hclk);
        check(32'(desc_q.size()), 32'd20);
        read(OFS_STAT, rd);
        check(rd & 32'h0000_1F01, 32'h0000_0000);
    endtask
    task t_bad_off;
        bad <= 1'b1;
        desc_q.delete();
        pulse(4'h2);
        wait_desc(4);
        bad <= 1'b0;
        check(desc_q[0], 32'h4000_0220);
        read(OFS_STAT, rd);
        check(rd & 32'h0000_0002, 32'h0000_0002);
        write(OFS_CTRL, 32'h0000_0000);
        n_req = 0;
        pulse(4'h9);
        repeat (20) @(posedge hclk);
        check(32'(n_req), 32'd0);
        // Channel 3 reset while disabled drops its pending trigger
        write(OFS_CHSEL, 32'h0000_0003);
        write(OFS_CHCTL, 32'h0000_0000);
        write(OFS_CHCTL, 32'h0000_0001);
        write(OFS_CHCTL, 32'h0000_0002);
        write(OFS_CTRL, 32'h0000_0002);
        repeat (40) @(posedge hclk);
        check(32'(n_req), 32'd4);
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_enables;
        t_channels;
        t_soft;
        t_fetch;
        t_fill;
        t_bad_off;
        end_of_test;
    end
endmodule
